/* design/tbw_top.sv */
`timescale 1ns/100ps
module tbw_top #(
	parameter logic [31:0] WDT_CYC [8] = tbw_pkg::WD_CYC_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [tbw_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// System signals
	output logic sys_irq,
	output logic wdt_sys_rst,
	output logic serr_n_o,
	output logic serr_n_oe
);
	import tbw_pkg::*;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tbw_tick_if tk ();
	logic [31:0] timer_control_one_reg;
	logic [31:0] timer_control_one_next;
	logic [31:0] timer_control_two_reg;
	logic [31:0] watchdog_control_reg;
	logic [31:0] load_one_two_reg;
	logic [31:0] load_three_reg;
	logic [31:0] timer_four_reload_value_reg;
	logic [31:0] cnt_reg [4];
	logic [31:0] latch_reg [4];
	logic pend_reg [4];
	logic [31:0] load_val [4];
	logic load_wr [4];
	logic tick_sel [4];
	logic tc [4];
	logic [3:0] clr_wr;
	logic [3:0] flags;
	logic [31:0] rd_mux;
	logic [31:0] rdata_reg;
	logic rvalid_reg;
	logic irq_reg;
	logic wd_rst_reg, serr_oe_reg, serr_out_reg;
	logic wd_expire;
	logic wd_restart;
	logic [31:0] wd_ctrl_wval;
	logic [2:0] wd_sel_now;
	logic latch_all;
	logic wr_ctrl1, wr_ctrl2, wr_wdctl, wr_kick;
	logic wr_load12, wr_load3, wr_load4;
	logic rd_cnt12, rd_cnt3, rd_cnt4;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign wr_ctrl1 = reg_wr && reg_addr == OFS_CTRL1;
	assign wr_ctrl2 = reg_wr && reg_addr == OFS_CTRL2;
	assign wr_wdctl = reg_wr && reg_addr == OFS_WD_CTRL;
	assign wr_kick = reg_wr && reg_addr == OFS_WD_KICK;
	assign wr_load12 = reg_wr && reg_addr == OFS_LOAD12;
	assign wr_load3 = reg_wr && reg_addr == OFS_LOAD3;
	assign wr_load4 = reg_wr && reg_addr == OFS_LOAD4;
	assign rd_cnt12 = reg_rd && reg_addr == OFS_CNT12;
	assign rd_cnt3 = reg_rd && reg_addr == OFS_CNT3;
	assign rd_cnt4 = reg_rd && reg_addr == OFS_CNT4;
	assign latch_all = timer_control_two_reg[LATCH_SEL_BIT];

	// Clear strobes ignore the data and the byte enables
	for (genvar i = 0; i < NTMR; i++) begin : g_clr
		assign clr_wr[i] = reg_wr && reg_addr == OFS_CLR[i];
		assign flags[i] = timer_control_one_reg[i*CTL_STRIDE + FLD_FLAG];
	end

	assign load_val[0] = {16'h0000, load_one_two_reg[15:0]};
	assign load_val[1] = {16'h0000, load_one_two_reg[31:16]};
	assign load_val[2] = load_three_reg;
	assign load_val[3] = timer_four_reload_value_reg;
	assign load_wr[0] = wr_load12 && |reg_be[1:0];
	assign load_wr[1] = wr_load12 && |reg_be[3:2];
	assign load_wr[2] = wr_load3 && |reg_be;
	assign load_wr[3] = wr_load4 && |reg_be;

	// ----------------------------------------------------------------
	// Configuration and load registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_control_two_reg <= CTRL2_RST;
			watchdog_control_reg <= WD_CTRL_RST;
			load_one_two_reg <= LOAD_RST;
			load_three_reg <= LOAD_RST;
			timer_four_reload_value_reg <= LOAD_RST;
		end else begin
			if (wr_ctrl2)
				timer_control_two_reg <= merge(timer_control_two_reg,
					reg_wdata, reg_be);
			if (wr_wdctl)
				watchdog_control_reg <= wd_ctrl_wval;
			if (wr_load12)
				load_one_two_reg <= merge(load_one_two_reg, reg_wdata, reg_be);
			if (wr_load3)
				load_three_reg <= merge(load_three_reg, reg_wdata, reg_be);
			if (wr_load4)
				timer_four_reload_value_reg <= merge(
					timer_four_reload_value_reg, reg_wdata, reg_be);
		end
	end

	// ----------------------------------------------------------------
	// Control one with cause flags
	// ----------------------------------------------------------------
	// A timeout with its interrupt enabled in the same cycle as a clear keeps the flag set
	always_comb begin
		timer_control_one_next = timer_control_one_reg;
		if (wr_ctrl1)
			timer_control_one_next = merge(timer_control_one_reg,
				reg_wdata, reg_be);
		for (int i = 0; i < NTMR; i++) begin
			timer_control_one_next[i*CTL_STRIDE + FLD_FLAG] =
				(tc[i] && timer_control_one_reg[i*CTL_STRIDE + FLD_IEN])
				|| (flags[i] && !clr_wr[i]
				&& timer_control_one_next[i*CTL_STRIDE + FLD_FLAG]);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			timer_control_one_reg <= CTRL1_RST;
		else
			timer_control_one_reg <= timer_control_one_next;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			irq_reg <= 1'b0;
		else
			irq_reg <= |flags;
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	tbw_prescaler u_prescaler (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.tk(tk.src)
	);

	for (genvar i = 0; i < NTMR; i++) begin : g_tmr
		assign tick_sel[i] =
			tk.tick[timer_control_one_reg[i*CTL_STRIDE + FLD_CS +: 2]];
		assign tc[i] = tick_sel[i] && !pend_reg[i]
			&& timer_control_one_reg[i*CTL_STRIDE + FLD_EN]
			&& cnt_reg[i] == 32'h0;

		// Load waits for the timer's own tick, enabled or not
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst)
				pend_reg[i] <= 1'b0;
			else if (load_wr[i])
				pend_reg[i] <= 1'b1;
			else if (tick_sel[i])
				pend_reg[i] <= 1'b0;
		end

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst)
				cnt_reg[i] <= 32'h0;
			else if (tick_sel[i] && pend_reg[i])
				cnt_reg[i] <= load_val[i];
			else if (tc[i])
				cnt_reg[i] <= load_val[i];
			else if (tick_sel[i] && timer_control_one_reg[i*CTL_STRIDE + FLD_EN])
				cnt_reg[i] <= (cnt_reg[i] - 32'h1) & CNT_MASK[i];
		end

		reload_tc_a :
		assert property (tc[i] |=> cnt_reg[i] == $past(load_val[i]))
			else $error("no reload at terminal count");
		count_dec_a :
		assert property (tick_sel[i] && !pend_reg[i] && !tc[i]
			&& timer_control_one_reg[i*CTL_STRIDE + FLD_EN]
			|=> cnt_reg[i] == (($past(cnt_reg[i]) - 32'h1) & CNT_MASK[i]))
			else $error("timer did not decrement");
		irq_clear_a :
		assert property (clr_wr[i] && !tc[i] |=> !flags[i])
			else $error("clear register left flag set");
		flag_set_a :
		assert property (tc[i] && timer_control_one_reg[i*CTL_STRIDE + FLD_IEN]
			|=> flags[i] ##1 sys_irq)
			else $error("timeout did not raise interrupt");
	end

	// ----------------------------------------------------------------
	// Count latches and read path
	// ----------------------------------------------------------------
	// Latch-all mode trades live reads of 0x24 and 0x28 for a snapshot
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NTMR; i++)
				latch_reg[i] <= 32'h0;
		end else begin
			if (rd_cnt12) begin
				latch_reg[0] <= cnt_reg[0];
				latch_reg[1] <= cnt_reg[1];
				if (latch_all) begin
					latch_reg[2] <= cnt_reg[2];
					latch_reg[3] <= cnt_reg[3];
				end
			end
			if (rd_cnt3 && !latch_all)
				latch_reg[2] <= cnt_reg[2];
			if (rd_cnt4 && !latch_all)
				latch_reg[3] <= cnt_reg[3];
		end
	end

	always_comb begin
		case (reg_addr)
			OFS_CTRL1: rd_mux = timer_control_one_reg;
			OFS_CTRL2: rd_mux = timer_control_two_reg;
			OFS_WD_CTRL: rd_mux = watchdog_control_reg;
			OFS_LOAD12: rd_mux = load_one_two_reg;
			OFS_LOAD3: rd_mux = load_three_reg;
			OFS_LOAD4: rd_mux = timer_four_reload_value_reg;
			OFS_CNT12: rd_mux = {cnt_reg[1][15:0], cnt_reg[0][15:0]};
			OFS_CNT3: rd_mux = latch_all ? latch_reg[2] : cnt_reg[2];
			OFS_CNT4: rd_mux = latch_all ? latch_reg[3] : cnt_reg[3];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
			rvalid_reg <= reg_rd;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// Restart must count the period of the select being written
	assign wd_ctrl_wval = merge(watchdog_control_reg, reg_wdata, reg_be)
		& WD_CTRL_MASK;
	assign wd_sel_now = wr_wdctl ? wd_ctrl_wval[WD_SEL_LSB +: 3]
		: watchdog_control_reg[WD_SEL_LSB +: 3];
	assign wd_restart = wr_kick || (wr_wdctl && reg_be[1]);

	tbw_watchdog #(
		.WDT_CYC(WDT_CYC)
	) u_watchdog (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.wd_en(watchdog_control_reg[WD_EN_BIT]),
		.wd_sel(wd_sel_now),
		.wd_restart(wd_restart),
		.wd_expire(wd_expire)
	);

	// SERR# is open drain: it is only ever pulled low
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_rst_reg <= 1'b0;
			serr_oe_reg <= 1'b0;
			serr_out_reg <= 1'b0;
		end else begin
			wd_rst_reg <= wd_expire && !watchdog_control_reg[WD_RESP_BIT];
			serr_oe_reg <= wd_expire && watchdog_control_reg[WD_RESP_BIT];
			serr_out_reg <= 1'b0;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign sys_irq = irq_reg;
	assign wdt_sys_rst = wd_rst_reg;
	assign serr_n_o = serr_out_reg;
	assign serr_n_oe = serr_oe_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	ld4_apply_a :
	assert property (pend_reg[3] && tick_sel[3]
		|=> cnt_reg[3] == $past(timer_four_reload_value_reg))
		else $error("timer four load not applied on tick");
	cnt12_read_a :
	assert property (rd_cnt12 |=> reg_rvalid
		&& reg_rdata == {latch_reg[1][15:0], latch_reg[0][15:0]})
		else $error("count one-two read mismatch");
	latch_all_a :
	assert property (rd_cnt12 && latch_all
		|=> latch_reg[3] == $past(cnt_reg[3]) && latch_reg[2] == $past(cnt_reg[2]))
		else $error("latch-all read missed a timer");
	cnt3_hold_a :
	assert property (rd_cnt3 && latch_all |=> reg_rdata == latch_reg[2])
		else $error("timer three snapshot not returned");
	cnt4_live_a :
	assert property (rd_cnt4 && !latch_all
		|=> reg_rdata == latch_reg[3] && latch_reg[3] == $past(cnt_reg[3]))
		else $error("timer four read not latched");
	flag_zero_a :
	assert property (wr_ctrl1 && reg_be[0] && !reg_wdata[FLD_FLAG] && !tc[0]
		|=> !flags[0])
		else $error("writing zero left flag one set");
	wdt_resp_a :
	assert property (wd_expire |=> (wdt_sys_rst != serr_n_oe) && !serr_n_o)
		else $error("watchdog response wrong");
	wdt_off_a :
	assert property (!watchdog_control_reg[WD_EN_BIT] |-> ##2 !wdt_sys_rst
		&& !serr_n_oe)
		else $error("disabled watchdog acted");

	tc_irq_c : cover property (tc[0] ##1 sys_irq [*2]);
	wdt_exp_c : cover property (wd_expire ##1 serr_n_oe);
	snap_c : cover property (rd_cnt12 && latch_all ##1 rd_cnt3);

endmodule // tbw_top

/* design/tbw_pkg.sv */
package tbw_pkg;

	// ----------------------------------------------------------------
	// Clock and register map
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int ADDR_W = 6;
	localparam int NTMR = 4;
	localparam logic [5:0] OFS_CTRL1 = 6'h00;
	localparam logic [5:0] OFS_CTRL2 = 6'h04;
	localparam logic [5:0] OFS_WD_CTRL = 6'h08;
	localparam logic [5:0] OFS_WD_KICK = 6'h0C;
	localparam logic [5:0] OFS_LOAD12 = 6'h10;
	localparam logic [5:0] OFS_LOAD3 = 6'h14;
	localparam logic [5:0] OFS_LOAD4 = 6'h18;
	localparam logic [5:0] OFS_CNT12 = 6'h20;
	localparam logic [5:0] OFS_CNT3 = 6'h24;
	localparam logic [5:0] OFS_CNT4 = 6'h28;
	localparam logic [5:0] OFS_CLR [4] = '{6'h30, 6'h34, 6'h38, 6'h3C};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTL_STRIDE = 8;
	localparam int FLD_FLAG = 0;
	localparam int FLD_EN = 1;
	localparam int FLD_IEN = 2;
	localparam int FLD_CS = 3;
	localparam int LATCH_SEL_BIT = 0;
	localparam int WD_EN_BIT = 0;
	localparam int WD_SEL_LSB = 8;
	localparam int WD_RESP_BIT = 16;
	localparam logic [31:0] WD_CTRL_MASK = 32'h0001_0701;
	localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
	localparam logic [31:0] WD_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] LOAD_RST = 32'h0000_0000;
	localparam logic [31:0] CNT_MASK [4] = '{32'h0000_FFFF, 32'h0000_FFFF,
		32'hFFFF_FFFF, 32'hFFFF_FFFF};

	// ----------------------------------------------------------------
	// Tick rates and watchdog timeouts
	// ----------------------------------------------------------------
	localparam int TICK_HZ [4] = '{2_000_000, 1_000_000, 500_000, 250_000};
	localparam int TICK_DIV [4] = '{CLK_HZ / TICK_HZ[0],
		CLK_HZ / TICK_HZ[1], CLK_HZ / TICK_HZ[2], CLK_HZ / TICK_HZ[3]};
	localparam longint WD_US [8] = '{135_000_000, 33_600_000, 2_100_000,
		524_000, 262_000, 131_000, 32_768, 2_048};
	localparam longint CLK_PER_US = longint'(CLK_HZ) / 1_000_000;
	localparam logic [31:0] WD_CYC_DEF [8] = '{
		32'(WD_US[0] * CLK_PER_US), 32'(WD_US[1] * CLK_PER_US),
		32'(WD_US[2] * CLK_PER_US), 32'(WD_US[3] * CLK_PER_US),
		32'(WD_US[4] * CLK_PER_US), 32'(WD_US[5] * CLK_PER_US),
		32'(WD_US[6] * CLK_PER_US), 32'(WD_US[7] * CLK_PER_US)};

endpackage

/* design/tbw_tick_if.sv */
`timescale 1ns/100ps
// Tick strobes, one per selectable rate
interface tbw_tick_if;
	logic [3:0] tick;
	modport src (output tick);
	modport dst (input tick);
endinterface // tbw_tick_if

/* design/tbw_prescaler.sv */
`timescale 1ns/100ps
module tbw_prescaler (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Tick strobes
	tbw_tick_if.src tk
);
	import tbw_pkg::*;

	// ----------------------------------------------------------------
	// One free-running divider per rate
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_div
		if (TICK_DIV[i] < 1 || TICK_DIV[i] > 64)
			$error("tick divider out of range");
		logic [5:0] div_reg;
		logic tick_reg;
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				div_reg <= 6'h00;
				tick_reg <= 1'b0;
			end else if (div_reg == 6'(TICK_DIV[i] - 1)) begin
				div_reg <= 6'h00;
				tick_reg <= 1'b1;
			end else begin
				div_reg <= div_reg + 6'h01;
				tick_reg <= 1'b0;
			end
		end
		assign tk.tick[i] = tick_reg;
	end

endmodule // tbw_prescaler

/* design/tbw_watchdog.sv */
`timescale 1ns/100ps
module tbw_watchdog #(
	parameter logic [31:0] WDT_CYC [8] = tbw_pkg::WD_CYC_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Control
	input wire logic wd_en,
	input wire logic [2:0] wd_sel,
	input wire logic wd_restart,
	// Expiry strobe
	output logic wd_expire
);
	import tbw_pkg::*;

	for (genvar k = 0; k < 8; k++) begin : g_chk
		if (WDT_CYC[k] < 2)
			$error("watchdog timeout too short");
	end

	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic expire_reg;

	// ----------------------------------------------------------------
	// Period counter
	// ----------------------------------------------------------------
	// Held at the full period while off, so enabling starts afresh
	always_comb begin
		count_next = count_reg - 32'h1;
		if (!wd_en || wd_restart)
			count_next = WDT_CYC[wd_sel] - 32'h1;
		else if (count_reg == 32'h0)
			count_next = WDT_CYC[wd_sel] - 32'h1;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			count_reg <= 32'h0;
		else
			count_reg <= count_next;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			expire_reg <= 1'b0;
		else
			expire_reg <= wd_en && !wd_restart && count_reg == 32'h0;
	end

	assign wd_expire = expire_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	wd_restart_a :
	assert property (@(posedge mclk) disable iff (sys_rst)
		wd_restart |=> !wd_expire ##1 !wd_expire)
		else $error("watchdog expired right after restart");

endmodule // tbw_watchdog

/* tb/tbw_host.sv */
`timescale 1ns/100ps
module tbw_host (
	// Clock
	input wire logic mclk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [tbw_pkg::ADDR_W-1:0] reg_addr,
	output logic [3:0] reg_be,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid
);
	import tbw_pkg::*;
	// ----------------
	// Bus cycles
	// ----------------
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h3F;
		reg_be = 4'hF;
		reg_wdata = 32'h0;
	end
	// Released lines flip so a stale value never looks live
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// Lane-selective write; lanes go back to all four afterwards
	task automatic wrb(input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		reg_be <= be;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		reg_be <= 4'hF;
	endtask
	// Answer is taken once settled, a cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
	endtask
endmodule // tbw_host

/* tb/timer_bank_and_watchdog_bench.sv */
`timescale 1ns/100ps
module timer_bank_and_watchdog_bench;
	import tbw_pkg::*;
	typedef struct packed {
		logic [5:0] a;
		logic hi;
		logic [1:0] cs;
		logic [7:0] d;
	} tbw_row_s;
	// ----------------
	// Setup
	// ----------------
	// Short timeouts keep the run brief
	localparam logic [31:0] CYC [8] = '{32'h190, 32'h12C, 32'hC8, 32'h64,
		32'h50, 32'h3C, 32'h28, 32'h14};
	// Count register, upper half, clock select, ticks in 200 cycles
	localparam tbw_row_s ROWS [4] = '{'{6'h20, 1'b0, 2'h0, 8'h28},
		'{6'h20, 1'b1, 2'h1, 8'h14}, '{6'h24, 1'b0, 2'h2, 8'h0A},
		'{6'h28, 1'b0, 2'h3, 8'h05}};
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr, reg_rd, reg_rvalid, sys_irq, wdt_sys_rst;
	logic serr_n_o, serr_n_oe;
	logic [5:0] reg_addr;
	logic [3:0] reg_be;
	logic [31:0] reg_wdata, reg_rdata, r1, r2, r3, ctl;
	int fail_count = 0;
	int n_tests = 0;
	int cyc, npulse;
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (wdt_sys_rst === 1'b1 || serr_n_oe === 1'b1) begin
			npulse <= npulse + 1;
		end
	end
	tbw_top #(.WDT_CYC(CYC)) tbw_top_i (.mclk(mclk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sys_irq(sys_irq),
		.wdt_sys_rst(wdt_sys_rst), .serr_n_o(serr_n_o),
		.serr_n_oe(serr_n_oe));
	tbw_host tbw_host_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// ----------------
	// Helpers
	// ----------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input logic [5:0] a, input logic [31:0] d);
		tbw_host_i.wr(a, d);
	endtask
	task automatic r(input logic [5:0] a, output logic [31:0] d);
		tbw_host_i.rd(a, d);
	endtask
	function automatic logic hit(input logic wd);
		return (wd ? (wdt_sys_rst | serr_n_oe) : sys_irq) === 1'b1;
	endfunction
	// Bounded wait; first look is a cycle on, past any stale pulse
	task automatic wait_hi(input logic wd, input int lim);
		cyc = 0;
		do begin
			@(posedge mclk);
			#1;
			cyc++;
		end while (cyc < lim && !hit(wd));
	endtask
	function automatic logic [31:0] pick(tbw_row_s s, logic [31:0] x);
		if (s.a != OFS_CNT12) return x;
		return s.hi ? {16'h0, x[31:16]} : {16'h0, x[15:0]};
	endfunction
	task automatic close_out();
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		npulse = 0;
		ctl = 32'h0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		r(OFS_WD_CTRL, r1);
		chk(r1, 32'h0);
		r(OFS_CTRL1, r1);
		chk(r1, 32'h0);
		chk({sys_irq, wdt_sys_rst, serr_n_oe}, 3'b000);
		w(OFS_LOAD12, 32'h1000_1000);
		w(OFS_LOAD3, 32'h1000);
		w(OFS_LOAD4, 32'h1000);
		r(OFS_LOAD4, r1);
		chk(r1, 32'h1000);
		r(6'h1C, r1);
		chk(r1, 32'h0);
		r(OFS_CLR[3], r1);
		chk(r1, 32'h0);
		repeat (50) @(posedge mclk);
		foreach (ROWS[i]) begin
			r(ROWS[i].a, r1);
			chk(pick(ROWS[i], r1), 32'h1000);
			ctl[8 * i +: 8] = {3'h0, ROWS[i].cs, 3'h2};
		end
		w(OFS_CTRL1, ctl);
		foreach (ROWS[i]) begin
			r(ROWS[i].a, r1);
			repeat (198) @(posedge mclk);
			r(ROWS[i].a, r2);
			r3 = pick(ROWS[i], r1) - pick(ROWS[i], r2);
			chk(r3, {24'h0, ROWS[i].d});
		end
		// Own reads must not relatch while latch-all is set
		w(OFS_CTRL2, 32'h1);
		r(OFS_CNT12, r1);
		r(OFS_CNT3, r1);
		repeat (96) @(posedge mclk);
		r(OFS_CNT3, r2);
		chk(r2, r1);
		repeat (98) @(posedge mclk);
		r(OFS_CNT12, r3);
		r(OFS_CNT3, r3);
		chk(r1 - r3, 32'hA);
		w(OFS_CTRL2, 32'h0);
		w(OFS_CTRL1, 32'h0);
		w(OFS_LOAD12, 32'h0003_0003);
		w(OFS_LOAD3, 32'h3);
		w(OFS_LOAD4, 32'h3);
		w(OFS_CTRL1, 32'h0606_0606);
		wait_hi(1'b0, 200);
		chk(sys_irq, 1'b1);
		r(OFS_CNT3, r1);
		repeat (198) @(posedge mclk);
		r(OFS_CNT3, r2);
		chk(r2, r1);
		chk(r1 & ~32'h3, 32'h0);
		w(OFS_CTRL1, 32'h0101_0101);
		r(OFS_CTRL1, r1);
		chk(r1, 32'h0101_0101);
		for (int n = 0; n < 4; n++) begin
			w(OFS_CLR[n], 32'hFFFF_FFFF);
			r(OFS_CTRL1, r1);
			chk(r1, 32'h0101_0101 << (8 * (n + 1)));
		end
		chk(sys_irq, 1'b0);
		w(OFS_CTRL1, 32'h0606_0606);
		wait_hi(1'b0, 200);
		repeat (40) @(posedge mclk);
		w(OFS_CTRL1, 32'h0101_0101);
		w(OFS_CTRL1, 32'h0100_0100);
		r(OFS_CTRL1, r1);
		chk(r1, 32'h0100_0100);
		w(OFS_CTRL1, 32'h0);
		r(OFS_CTRL1, r1);
		chk(r1, 32'h0);
		w(OFS_WD_CTRL, 32'hFFFF_FFFF);
		r(OFS_WD_CTRL, r1);
		chk(r1, 32'h0001_0701);
		w(OFS_WD_CTRL, 32'h0);
		for (int s = 0; s < 8; s++) begin
			w(OFS_WD_CTRL, {15'h0, s[0], 5'h0, s[2:0], 8'h01});
			wait_hi(1'b1, 500);
			chk(cyc >= CYC[s] - 2 && cyc <= CYC[s] + 3, 1'b1);
			chk({wdt_sys_rst, serr_n_oe, serr_n_o}, {~s[0], s[0], 1'b0});
			@(posedge mclk);
			#1;
			chk(wdt_sys_rst | serr_n_oe, 1'b0);
		end
		w(OFS_WD_CTRL, 32'h0000_0301);
		npulse = 0;
		for (int k = 0; k < 8; k++) begin
			repeat (40) @(posedge mclk);
			w(OFS_WD_KICK, {32{k[0]}});
		end
		chk(npulse, 0);
		repeat (150) @(posedge mclk);
		chk(npulse, 1);
		sys_rst <= 1'b1;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		r(OFS_WD_CTRL, r1);
		chk(r1, 32'h0);
		r(OFS_LOAD4, r1);
		chk(r1, 32'h0);
		// Lanes 1:0 only; timer four takes it while still disabled
		tbw_host_i.wrb(OFS_LOAD4, 32'hFFFF_5678, 4'h3);
		r(OFS_LOAD4, r1);
		chk(r1, 32'h0000_5678);
		repeat (10) @(posedge mclk);
		r(OFS_CNT4, r1);
		chk(r1, 32'h0000_5678);
		npulse = 0;
		repeat (500) @(posedge mclk);
		chk(npulse, 0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		close_out();
	end
endmodule // timer_bank_and_watchdog_bench
